// *** inc/csk_pkg.sv ***
// constants and types for the conditional-skip execution block
package csk_pkg;
    // ***************************************
    // instruction select codes
    // ***************************************
    localparam logic [1:0] OP_NONE      = 2'h0;
    localparam logic [1:0] OP_PORT_C    = 2'h1;
    localparam logic [1:0] OP_EXT_PIN   = 2'h2;
    localparam logic [1:0] OP_POWERDOWN = 2'h3;

    // ***************************************
    // field positions and reset values
    // ***************************************
    localparam int         POL_BIT      = 2;
    localparam logic [3:0] IC1_RESET    = 4'h0;
    localparam logic [9:0] PC_RESET     = 10'h000;
    localparam logic [9:0] PC_STEP      = 10'h001;
    localparam logic [9:0] PC_SKIP_STEP = 10'h002;
    localparam int         SYNC_STAGES  = 2;

    // ***************************************
    // sequencer states
    // ***************************************
    typedef enum logic [1:0] {
        CSK_FETCH = 2'b01,
        CSK_SKIP  = 2'b10
    } csk_state_e;
endpackage

// *** rtl/csk_sync.sv ***
// two-flop synchroniser for one asynchronous level
module csk_sync
    import csk_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic [SYNC_STAGES-1:0] stage;

    // first stage feeds only the second
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
        end else begin
            stage <= {stage[SYNC_STAGES-2:0], din};
        end
    end

    assign dout = stage[SYNC_STAGES-1];
endmodule

// *** rtl/csk_skip_exec.sv ***
// conditional-skip instruction execution logic
// Function
// - the port-C skip instruction skips the next instruction when the port C input is one.
// - the port-C skip instruction lets the next instruction execute when port C is zero.
// - the pin-level skip takes its polarity from bit 2 of interrupt control register one.
// - with polarity zero the pin-level skip skips when the external pin is low.
// - with polarity one the pin-level skip skips when the external pin is high.
// - the power-down skip skips the next instruction when the power-down flag is one.
// - testing the power-down flag leaves the flag unchanged.
module csk_skip_exec
    import csk_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       instr_valid,
    input  wire logic [1:0] instr_op,
    input  wire logic       port_c_pin,
    input  wire logic       ext_int_pin,
    input  wire logic [3:0] interrupt_control_one,
    input  wire logic       powerdown_flag,
    input  wire logic       carry_in,
    output logic [9:0]      pc,
    output logic            skip_taken,
    output logic            next_suppressed,
    output logic            carry_out,
    output logic            powerdown_flag_out
);
    // ***************************************
    // reset release
    // ***************************************
    logic [1:0] rst_pipe;
    logic       rst_sync_n;
    logic       port_c_s;
    logic       ext_pin_s;

    // asserts at once, releases on the clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // ***************************************
    // pin synchronisers
    // ***************************************
    // pins are asynchronous to the core clock
    csk_sync u_sync_port_c (
        .ref_clk (ref_clk),
        .rst_n   (rst_sync_n),
        .din     (port_c_pin),
        .dout    (port_c_s)
    );
    csk_sync u_sync_ext (
        .ref_clk (ref_clk),
        .rst_n   (rst_sync_n),
        .din     (ext_int_pin),
        .dout    (ext_pin_s)
    );

    // ***************************************
    // skip condition
    // ***************************************
    logic ext_pin_polarity_select;
    logic op_port_c;
    logic op_ext_pin;
    logic op_powerdown;
    logic port_c_hit;
    logic ext_pin_hit;
    logic powerdown_hit;
    logic cond;

    assign ext_pin_polarity_select = interrupt_control_one[POL_BIT];

    // ***************************************
    // instruction decode
    // ***************************************
    // no-op code runs as a plain instruction
    always_comb begin
        op_port_c    = 1'b0;
        op_ext_pin   = 1'b0;
        op_powerdown = 1'b0;
        case (instr_op)
            OP_PORT_C: begin
                op_port_c = 1'b1;
            end
            OP_EXT_PIN: begin
                op_ext_pin = 1'b1;
            end
            OP_POWERDOWN: begin
                op_powerdown = 1'b1;
            end
            default: begin
                op_port_c    = 1'b0;
                op_ext_pin   = 1'b0;
                op_powerdown = 1'b0;
            end
        endcase
    end

    // ***************************************
    // per-instruction conditions
    // ***************************************
    // port c level
    assign port_c_hit = op_port_c && port_c_s;

    assign ext_pin_hit = op_ext_pin && (ext_pin_s == ext_pin_polarity_select);

    assign powerdown_hit = op_powerdown && powerdown_flag;

    // codes are exclusive, one hit at most
    // no hit, no skip
    assign cond = port_c_hit || ext_pin_hit || powerdown_hit;

    // ***************************************
    // slot qualification
    // ***************************************
    csk_state_e state;
    logic       slot_live;
    logic       slot_dropped;
    logic       do_skip;

    // a skip op in a dropped slot is ignored
    assign slot_live    = instr_valid && (state == CSK_FETCH);
    assign slot_dropped = instr_valid && (state == CSK_SKIP);
    assign do_skip      = slot_live && cond;

    // ***************************************
    // sequencer
    // ***************************************
    // skip state waits for the next valid slot
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= CSK_FETCH;
        end else begin
            case (state)
                CSK_FETCH: begin
                    if (do_skip) begin
                        state <= CSK_SKIP;
                    end
                end
                CSK_SKIP: begin
                    if (slot_dropped) begin
                        state <= CSK_FETCH;
                    end
                end
                // stray codes recover to fetch
                default: begin
                    state <= CSK_FETCH;
                end
            endcase
        end
    end

    // ***************************************
    // program counter
    // ***************************************
    logic [9:0] pc_plus_one;
    logic [9:0] pc_plus_two;

    // wraps at the top of the 10-bit space
    assign pc_plus_one = 10'(pc + PC_STEP);
    assign pc_plus_two = 10'(pc + PC_SKIP_STEP);

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pc <= PC_RESET;
        end else if (do_skip) begin
            pc <= pc_plus_two;
        end else if (slot_live) begin
            pc <= pc_plus_one;
        end
    end

    // ***************************************
    // skip report
    // ***************************************
    // registered, so the pulse is clean
    // one-cycle skip pulse
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            skip_taken <= 1'b0;
        end else begin
            skip_taken <= do_skip;
        end
    end

    assign next_suppressed = (state == CSK_SKIP);

    // ***************************************
    // carry pass-through
    // ***************************************
    // copy only, carry is never written here
    // carry left unchanged
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            carry_out <= 1'b0;
        end else begin
            carry_out <= carry_in;
        end
    end

    // ***************************************
    // power-down flag
    // ***************************************
    // flag not cleared
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            powerdown_flag_out <= 1'b0;
        end else begin
            powerdown_flag_out <= powerdown_flag;
        end
    end
endmodule

// *** sim/csk_skip_checker.sv ***
// assertions for the conditional-skip block
module csk_skip_checker
    import csk_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       instr_valid,
    input wire logic [1:0] instr_op,
    input wire logic       port_c_pin,
    input wire logic       ext_int_pin,
    input wire logic [3:0] interrupt_control_one,
    input wire logic       powerdown_flag,
    input wire logic       carry_in,
    input wire logic [9:0] pc,
    input wire logic       skip_taken,
    input wire logic       next_suppressed,
    input wire logic       carry_out,
    input wire logic       powerdown_flag_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take; instr_valid && !next_suppressed; endsequence
    // pins reach the decision through two sync flops
    property p_pc1; s_take ##0 instr_op == OP_PORT_C && $past(port_c_pin, 2) |=> skip_taken && next_suppressed; endproperty
    a_pc1: assert property (p_pc1) else $error("port c skip missed");
    property p_pc0; s_take ##0 instr_op == OP_PORT_C && !$past(port_c_pin, 2) |=> !skip_taken; endproperty
    a_pc0: assert property (p_pc0) else $error("port c false skip");
    property p_pol; s_take ##0 instr_op == OP_EXT_PIN |=>
        skip_taken == ($past(ext_int_pin, 3) == $past(interrupt_control_one[POL_BIT])); endproperty
    a_pol: assert property (p_pol) else $error("pin skip polarity");
    property p_lo; s_take ##0 instr_op == OP_EXT_PIN && !interrupt_control_one[POL_BIT] && !$past(ext_int_pin, 2)
        |=> skip_taken; endproperty
    a_lo: assert property (p_lo) else $error("low pin skip missed");
    property p_lo_run; s_take ##0 instr_op == OP_EXT_PIN && !interrupt_control_one[POL_BIT] && $past(ext_int_pin, 2)
        |=> !skip_taken; endproperty
    a_lo_run: assert property (p_lo_run) else $error("low polarity false skip");
    property p_hi; s_take ##0 instr_op == OP_EXT_PIN && interrupt_control_one[POL_BIT] && !$past(ext_int_pin, 2)
        |=> !skip_taken; endproperty
    a_hi: assert property (p_hi) else $error("high polarity false skip");
    property p_hi_skip; s_take ##0 instr_op == OP_EXT_PIN && interrupt_control_one[POL_BIT] && $past(ext_int_pin, 2)
        |=> skip_taken; endproperty
    a_hi_skip: assert property (p_hi_skip) else $error("high pin skip missed");
    property p_pd; s_take ##0 instr_op == OP_POWERDOWN |=> skip_taken == $past(powerdown_flag); endproperty
    a_pd: assert property (p_pd) else $error("power-down skip");
    property p_keep; s_take |=> powerdown_flag_out == $past(powerdown_flag) && carry_out == $past(carry_in); endproperty
    a_keep: assert property (p_keep) else $error("flag or carry altered");
    property p_step; s_take |=> pc == $past(pc) + (skip_taken ? PC_SKIP_STEP : PC_STEP); endproperty
    a_step: assert property (p_step) else $error("pc step wrong");
    property p_drop; instr_valid && next_suppressed |=> pc == $past(pc) && !skip_taken; endproperty
    a_drop: assert property (p_drop) else $error("skipped slot ran");
    property p_hold; next_suppressed && !instr_valid |=> next_suppressed && pc == $past(pc); endproperty
    a_hold: assert property (p_hold) else $error("skip state lost while idle");
endmodule
bind csk_skip_exec csk_skip_checker chk_u (.*);

// *** sim/csk_skip_exec_tb.sv ***
// self-checking bench for the conditional-skip block
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module csk_skip_exec_tb
    import csk_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, port_c_pin = 1'b0;
    logic ext_int_pin = 1'b0, powerdown_flag = 1'b0, carry_in = 1'b0;
    logic [1:0] instr_op = OP_NONE;
    logic [3:0] interrupt_control_one = IC1_RESET;
    logic [9:0] pc;
    logic skip_taken, next_suppressed, carry_out, powerdown_flag_out;
    int n_fail = 0, n_checks = 0;
    csk_skip_exec dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
        .port_c_pin(port_c_pin), .ext_int_pin(ext_int_pin), .interrupt_control_one(interrupt_control_one),
        .powerdown_flag(powerdown_flag), .carry_in(carry_in), .pc(pc), .skip_taken(skip_taken),
        .next_suppressed(next_suppressed), .carry_out(carry_out), .powerdown_flag_out(powerdown_flag_out));
    initial forever #10 ref_clk = ~ref_clk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // two back-to-back slots: the second is dropped after a skip, so pc ends +2 either way
    task automatic run(input logic [1:0] op, input logic exp);
        logic [9:0] p0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) p0 = pc;
        @(posedge ref_clk) begin instr_valid <= 1'b1; instr_op <= op; end
        @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(skip_taken, exp)
        `CHK(next_suppressed, exp)
        `CHK(pc, p0 + (exp ? PC_SKIP_STEP : PC_STEP))
        @(posedge ref_clk) instr_valid <= 1'b0;
        @(negedge ref_clk);
        `CHK({pc, skip_taken, next_suppressed, carry_out}, {p0 + PC_SKIP_STEP, 1'b0, 1'b0, carry_in})
    endtask
    task automatic t_port_c();
        @(posedge ref_clk) port_c_pin <= 1'b1;
        run(OP_PORT_C, 1'b1);
        run(OP_NONE, 1'b0);
        @(posedge ref_clk) begin port_c_pin <= 1'b0; carry_in <= 1'b1; end
        run(OP_PORT_C, 1'b0);
    endtask
    // skip state stands through idle cycles and drops only the next valid slot
    task automatic t_hold();
        logic [9:0] p0;
        @(posedge ref_clk) port_c_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) p0 = pc;
        @(posedge ref_clk) begin instr_valid <= 1'b1; instr_op <= OP_PORT_C; end
        @(posedge ref_clk) instr_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK({pc, next_suppressed}, {p0 + PC_SKIP_STEP, 1'b1})
        @(posedge ref_clk) instr_valid <= 1'b1;
        @(posedge ref_clk) instr_valid <= 1'b0;
        @(negedge ref_clk);
        `CHK({pc, skip_taken, next_suppressed}, {p0 + PC_SKIP_STEP, 1'b0, 1'b0})
    endtask
    task automatic t_ext_pin();
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk) begin interrupt_control_one <= {1'b1, i[1], 2'h1}; ext_int_pin <= i[0]; end
            run(OP_EXT_PIN, i[1] == i[0]);
        end
    endtask
    task automatic t_powerdown();
        @(posedge ref_clk) powerdown_flag <= 1'b1;
        run(OP_POWERDOWN, 1'b1);
        `CHK(powerdown_flag_out, 1'b1)
        @(posedge ref_clk) powerdown_flag <= 1'b0;
        run(OP_POWERDOWN, 1'b0);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_port_c();
        t_hold();
        t_ext_pin();
        t_powerdown();
        final_report();
    end
    // bounded run, over thirteen times the expected length
    initial begin
        repeat (1200) @(posedge ref_clk);
        n_fail++;
        final_report();
    end
endmodule
